// ### src/epio_cfg.svh
// Purpose: Offsets, reset values and codes of the eight-pin port
// Assumes: Byte-wide register port, one word per offset
// Notes: Included by the package and the port module
`ifndef EPIO_CFG_SVH
`define EPIO_CFG_SVH

// Register offsets
`define EPIO_OFS_LATCH 8'h00
`define EPIO_OFS_DIR 8'h01
`define EPIO_OFS_OPT 8'h02
`define EPIO_OFS_SENS 8'h03

// Reset values
`define EPIO_RST_BYTE 8'h00
`define EPIO_RST_SENS 2'h0

// Sensitivity codes
`define EPIO_SENS_FALL_LOW 2'h0
`define EPIO_SENS_RISE 2'h1
`define EPIO_SENS_FALL 2'h2
`define EPIO_SENS_BOTH 2'h3

// Field width of the sensitivity control
`define EPIO_SENS_W 2

`endif

// ### src/epio_pkg.sv
// Purpose: Types shared by the eight-pin port and its users
// Assumes: Constants come from epio_cfg.svh
// Notes: Carries the register port and peripheral groups
`include "epio_cfg.svh"

package epio_pkg;

    // Register port request from the processor
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } epio_bus_req_type;

    // Signals of on-chip peripherals that may take a pin
    typedef struct packed {
        logic [7:0] out_en;
        logic [7:0] out_val;
        logic [7:0] out_od;
        logic [7:0] in_en;
    } epio_alt_type;

    // Edge or level sensitivity of the interrupt group
    typedef logic [`EPIO_SENS_W-1:0] epio_sens_type;

endpackage

// ### src/epio_port.sv
// Purpose: Eight-pin general purpose port with alternate functions
// Assumes: One clock, pins already buffered by pads outside
// Notes: All eight pins share one external interrupt request
`timescale 1ns/1ps
`include "epio_cfg.svh"

module epio_port #(
    parameter logic [7:0] PULLUP_CAP = 8'hFF,
    parameter logic [7:0] IRQ_CAP = 8'hFF,
    parameter logic [7:0] PUSHPULL_CAP = 8'hFF,
    parameter logic [7:0] TRUE_OD = 8'h00
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire epio_pkg::epio_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pull_en,
    input wire epio_pkg::epio_alt_type alt,
    output logic [7:0] alt_in,
    input wire logic cpu_irq_mask,
    input wire logic irq_vector_fetch,
    output logic ext_irq_req
);

    // Software-visible registers
    logic [7:0] pin_output_latch_reg;
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_option_select_reg;
    epio_pkg::epio_sens_type interrupt_sensitivity_ctrl_reg;

    // Synchroniser stages and previous sample
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic [7:0] pin_prev_reg;

    // Interrupt request latch, hidden from software
    logic irq_latch_reg;

    // Per-pin decoded configuration
    logic [7:0] out_mode;
    logic [7:0] drive_val;
    logic [7:0] open_drain;
    logic [7:0] drive_on;
    logic [7:0] irq_en;
    logic [7:0] pin_evt;
    logic [7:0] pin_low_en;
    logic [7:0] read_view;
    logic [7:0] pin_out_next;
    logic [7:0] pin_oe_n_next;
    logic [7:0] pull_en_next;
    logic [7:0] alt_in_next;
    logic [7:0] bus_rdata_next;
    logic any_evt;
    logic level_req;
    logic wr_latch;
    logic wr_dir;
    logic wr_opt;
    logic wr_sens;
    logic rd_hit;
    logic [3:0] reg_sel;
    logic sens_clr;

    // Pad limits folded once; a true open-drain pad can neither pull nor push,
    // so a peripheral asking for push-pull on such a pad only gets open-drain
    localparam logic [7:0] PULL_OK = PULLUP_CAP & ~TRUE_OD;
    localparam logic [7:0] PUSH_OK = PUSHPULL_CAP & ~TRUE_OD;

    // Edge detector for one pin under the chosen sensitivity
    function automatic logic epio_edge(
        input epio_pkg::epio_sens_type mode,
        input logic prev,
        input logic cur
    );
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        case (mode)
            `EPIO_SENS_RISE: epio_edge = rise;
            `EPIO_SENS_BOTH: epio_edge = rise | fall;
            default: epio_edge = fall;
        endcase
    endfunction

    // One-hot register select, shared by write decode and read mux
    // so a write and a read of one offset always reach the same register
    function automatic logic [3:0] epio_sel(
        input logic [7:0] addr
    );
        epio_sel = 4'h0;
        if (addr == `EPIO_OFS_LATCH) begin
            epio_sel = 4'h1;
        end else if (addr == `EPIO_OFS_DIR) begin
            epio_sel = 4'h2;
        end else if (addr == `EPIO_OFS_OPT) begin
            epio_sel = 4'h4;
        end else if (addr == `EPIO_OFS_SENS) begin
            epio_sel = 4'h8;
        end
    endfunction

    // Address decode of the register port
    always_comb begin
        reg_sel = epio_sel(bus_req.addr);
        wr_latch = bus_req.wr & reg_sel[0];
        wr_dir = bus_req.wr & reg_sel[1];
        wr_opt = bus_req.wr & reg_sel[2];
        wr_sens = bus_req.wr & reg_sel[3];
        rd_hit = |reg_sel;
    end

    // Only a write that alters the code drops a pending request
    assign sens_clr = wr_sens
        & (bus_req.wdata[`EPIO_SENS_W-1:0] != interrupt_sensitivity_ctrl_reg);

    // Data latch; written in every mode, drives only outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_output_latch_reg <= `EPIO_RST_BYTE;
        end else if (wr_latch) begin
            pin_output_latch_reg <= bus_req.wdata;
        end
    end

    // Direction register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_direction_reg <= `EPIO_RST_BYTE;
        end else if (wr_dir) begin
            pin_direction_reg <= bus_req.wdata;
        end
    end

    // Option register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_option_select_reg <= `EPIO_RST_BYTE;
        end else if (wr_opt) begin
            pin_option_select_reg <= bus_req.wdata;
        end
    end

    // Sensitivity control, low bits of its byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_sensitivity_ctrl_reg <= `EPIO_RST_SENS;
        end else if (wr_sens) begin
            interrupt_sensitivity_ctrl_reg <= bus_req.wdata[`EPIO_SENS_W-1:0];
        end
    end

    // Two flops before any logic sees a pin; third is edge history
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
            pin_prev_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Per-pin mode decode, each pin on its own bits
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            // Peripheral output wins over direction and latch
            assign out_mode[gi] = alt.out_en[gi] | pin_direction_reg[gi];
            assign drive_val[gi] = alt.out_en[gi] ? alt.out_val[gi]
                                                  : pin_output_latch_reg[gi];
            // Pad limits apply to the peripheral too: no push on weak pads
            assign open_drain[gi] = ~PUSH_OK[gi]
                | (alt.out_en[gi] ? alt.out_od[gi]
                   : ~pin_option_select_reg[gi]);
            // Open-drain high releases the pin
            assign drive_on[gi] = out_mode[gi]
                & (~drive_val[gi] | ~open_drain[gi]);
            // Pull-up only on capable, non-true-open-drain inputs
            assign pull_en_next[gi] = ~out_mode[gi] & pin_option_select_reg[gi]
                & PULL_OK[gi];
            // Interrupt input: input mode, option set, capable pad
            assign irq_en[gi] = ~pin_direction_reg[gi]
                & pin_option_select_reg[gi] & IRQ_CAP[gi];
            assign pin_evt[gi] = irq_en[gi] & epio_edge(interrupt_sensitivity_ctrl_reg,
                pin_prev_reg[gi], pin_sync_reg[gi]);
            assign pin_low_en[gi] = irq_en[gi] & ~pin_sync_reg[gi];
            // Read view: latch, peripheral output or pin level
            assign read_view[gi] = pin_direction_reg[gi] ? pin_output_latch_reg[gi]
                : (alt.out_en[gi] ? alt.out_val[gi]
                   : pin_sync_reg[gi]);
            // Peripheral input sees the latch on output pins
            assign alt_in_next[gi] = alt.in_en[gi]
                & (pin_direction_reg[gi] ? pin_output_latch_reg[gi]
                   : pin_sync_reg[gi]);
        end
    endgenerate

    // Pin drive values; high-z is left to the pad
    always_comb begin
        pin_out_next = drive_val;
        pin_oe_n_next = ~drive_on;
    end

    // Pads are driven from flops to avoid glitches on pins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= 8'h00;
            pin_oe_n <= 8'hFF;
            pull_en <= 8'h00;
            alt_in <= 8'h00;
        end else begin
            pin_out <= pin_out_next;
            pin_oe_n <= pin_oe_n_next;
            pull_en <= pull_en_next;
            alt_in <= alt_in_next;
        end
    end

    // All enabled sources merged onto the one vector
    assign any_evt = |pin_evt;
    // Low-level mode also asserts while any source sits low
    assign level_req = (interrupt_sensitivity_ctrl_reg == `EPIO_SENS_FALL_LOW)
                       & (|pin_low_en);

    // Request latch; a new event beats fetch or sensitivity clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_latch_reg <= 1'b0;
        end else if (any_evt) begin
            irq_latch_reg <= 1'b1;
        end else if (irq_vector_fetch) begin
            irq_latch_reg <= 1'b0;
        end else if (sens_clr) begin
            irq_latch_reg <= 1'b0;
        end
    end

    // Request reaches the processor only when unmasked
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_irq_req <= 1'b0;
        end else begin
            ext_irq_req <= (irq_latch_reg | level_req) & ~cpu_irq_mask;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        bus_rdata_next = 8'h00;
        if (reg_sel[0]) begin
            bus_rdata_next = read_view;
        end else if (reg_sel[1]) begin
            bus_rdata_next = pin_direction_reg;
        end else if (reg_sel[2]) begin
            bus_rdata_next = pin_option_select_reg;
        end else if (reg_sel[3]) begin
            bus_rdata_next = {6'h00, interrupt_sensitivity_ctrl_reg};
        end
    end

    // Read data stands one cycle after the strobe, else zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd & rd_hit) begin
            bus_rdata <= bus_rdata_next;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule

// ### verification/epio_port_sva.sv
// Purpose: Port-level checks of the eight-pin port
// Assumes: Registered outputs, one clock, reset active high
// Notes: Bound to the port from the bench top
`timescale 1ns/1ps
module epio_port_sva #(
    parameter logic [7:0] PULLUP_CAP = 8'hFF,
    parameter logic [7:0] PUSHPULL_CAP = 8'hFF,
    parameter logic [7:0] TRUE_OD = 8'h00
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire epio_pkg::epio_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_en,
    input wire epio_pkg::epio_alt_type alt,
    input wire logic [7:0] alt_in,
    input wire logic cpu_irq_mask,
    input wire logic ext_irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pins able to drive high at all
    logic [7:0] pp_ok;
    assign pp_ok = PUSHPULL_CAP & ~TRUE_OD;
    rst_vals_a: assert property (disable iff (1'b0) sys_rst |-> pin_oe_n == 8'hFF
        && pin_out == 8'h00 && pull_en == 8'h00 && !ext_irq_req) else $error("reset state");
    rd_window_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its cycle");
    pull_drive_a: assert property ((pull_en & ~pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    cap_limit_a: assert property ((pull_en & ~(PULLUP_CAP & ~TRUE_OD)) == 8'h00
        && (~pin_oe_n & pin_out & TRUE_OD) == 8'h00) else $error("pin capability");
    alt_force_a: assert property (($past(alt.out_en & ~alt.out_od) & pp_ok
        & pin_oe_n) == 8'h00) else $error("peripheral output not driven");
    alt_val_a: assert property (($past(alt.out_en) & ~pin_oe_n
        & (pin_out ^ $past(alt.out_val))) == 8'h00) else $error("peripheral value");
    alt_in_off_a: assert property ((alt_in & ~$past(alt.in_en)) == 8'h00)
        else $error("peripheral input not idle");
    irq_mask_a: assert property (cpu_irq_mask [*2] |-> !ext_irq_req)
        else $error("request while masked");
    irq_rise_a: assert property ($rose(ext_irq_req) |-> !$past(cpu_irq_mask))
        else $error("request rose under mask");
endmodule

// ### verification/epio_board.sv
// Purpose: Board circuitry seen by the eight pins
// Assumes: Bench drives only pins the port leaves released
// Notes: Undriven pins without pull-up wander every cycle
`timescale 1ns/1ps
module epio_board (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] float_reg = 8'h5A;
    // Floating level changes each cycle so no stale value passes
    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // Released pins take the bench value, else go to pull-up or float
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & (pull_en | float_reg));
endmodule

// ### verification/epio_port_tb.sv
// Purpose: Self-checking bench of the eight-pin port
// Assumes: Board model on the pins, bus driven at rising edges
// Notes: Random configurations, then a sweep of sensitivity codes
`timescale 1ns/1ps
module epio_port_tb;
    localparam logic [7:0] PU = 8'hF7;
    localparam logic [7:0] IQ = 8'h0F;
    localparam logic [7:0] PP = 8'hBF;
    localparam logic [7:0] OD = 8'h80;
    logic clk = 1'b0;
    logic sys_rst = 1'b0;
    logic cpu_irq_mask = 1'b0;
    logic irq_vector_fetch = 1'b0;
    epio_pkg::epio_bus_req_type bus_req = '0;
    epio_pkg::epio_alt_type alt = '0;
    epio_pkg::epio_alt_type na;
    logic [7:0] bus_rdata, pin_in, pin_out, pin_oe_n, pull_en, alt_in, l, d, ro, o, rv, dv;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    logic ext_irq_req;
    int mismatches = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    epio_port #(.PULLUP_CAP(PU), .IRQ_CAP(IQ), .PUSHPULL_CAP(PP), .TRUE_OD(OD)) dut (
        .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
        .alt(alt), .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask),
        .irq_vector_fetch(irq_vector_fetch), .ext_irq_req(ext_irq_req));
    epio_board board (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // Pins expected to be driven
    function automatic logic [7:0] drv_exp();
        return (na.out_en & (~na.out_val | (~na.out_od & PP & ~OD)))
            | (~na.out_en & d & (~l | (o & PP & ~OD)));
    endfunction
    // Latch read: latch on outputs, peripheral value or pin on inputs
    function automatic logic [7:0] rd_exp();
        return (d & l) | (~d & ((na.out_en & na.out_val) | (~na.out_en & rv)));
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask
    task automatic pins(input logic [7:0] v);
        @(posedge clk) ext_val <= v;
        idle(8);
    endtask
    task automatic fetch();
        @(posedge clk) irq_vector_fetch <= 1'b1;
        @(posedge clk) irq_vector_fetch <= 1'b0;
        idle(4);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far beyond the roughly 1,300 cycles of the run
    initial begin
        #2000000;
        mismatches++;
        close_out();
    end
    // Main sequence
    initial begin
        sys_rst <= 1'b1;
        void'($urandom(32'h26741838));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 4; a++) rchk(8'(a), 8'h00);
        wr(8'h05, 8'hFF);
        rchk(8'h05, 8'h00);
        wr(8'h03, 8'hFF);
        rchk(8'h03, 8'h03);
        for (int i = 0; i < 60; i++) begin
            {l, d, ro, rv} = $urandom;
            na = $urandom;
            na.out_en = na.out_en & 8'($urandom);
            na.in_en = na.in_en & ~na.out_en;
            if (i == 0) {l, d, ro, na} = {24'hFFFFFF, 32'h0};
            if (i == 1) {l, d, ro, na} = {24'h0000FF, 32'h0};
            o = ro & ~(~d & (na.out_en | na.in_en));
            @(posedge clk) begin
                alt <= na;
                ext_en <= ~d & ~na.out_en;
                ext_val <= rv;
            end
            wr(8'h00, l);
            wr(8'h02, o);
            wr(8'h01, d);
            idle(4);
            dv = drv_exp();
            chk(~pin_oe_n, dv);
            chk(pin_out & dv, ((na.out_en & na.out_val) | (~na.out_en & l)) & dv);
            chk(pull_en, ~d & o & PU & ~OD);
            chk(alt_in, na.in_en & ((d & l) | (~d & rv)));
            rchk(8'h00, rd_exp());
            rchk(8'h01, d);
            rchk(8'h02, o);
        end
        @(posedge clk) begin
            alt <= '0;
            ext_en <= 8'hFF;
            ext_val <= 8'hFF;
        end
        // Mid-run reset drops every register, pins released again
        @(posedge clk) sys_rst <= 1'b1;
        idle(2);
        chk(pin_oe_n, 8'hFF);
        @(posedge clk) sys_rst <= 1'b0;
        for (int a = 1; a < 4; a++) rchk(8'(a), 8'h00);
        // Input first, then option: a safe way into interrupt input
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h03);
        for (int c = 0; c < 4; c++) begin
            idle(8);
            wr(8'h03, 8'(c));
            idle(4);
            chk({7'h0, ext_irq_req}, 8'h00);
            pins(8'hFE);
            chk({7'h0, ext_irq_req}, {7'h0, c != 1});
            @(posedge clk) cpu_irq_mask <= 1'b1;
            idle(3);
            chk({7'h0, ext_irq_req}, 8'h00);
            @(posedge clk) cpu_irq_mask <= 1'b0;
            pins(8'hFF);
            fetch();
            chk({7'h0, ext_irq_req}, 8'h00);
            pins(8'hFD);
            fetch();
            chk({7'h0, ext_irq_req}, {7'h0, c == 0});
            pins(8'hFF);
            chk({7'h0, ext_irq_req}, {7'h0, c == 1 || c == 3});
        end
        close_out();
    end
endmodule
bind epio_port epio_port_sva #(.PULLUP_CAP(PULLUP_CAP), .PUSHPULL_CAP(PUSHPULL_CAP),
    .TRUE_OD(TRUE_OD)) sva_i (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
    .alt(alt), .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask), .ext_irq_req(ext_irq_req));
